// ### design/sensor_regs_pkg.sv
// constants shared by the mode, status and configuration register logic
// assumes a single clk_sys domain and a synchronous active-high reset
package sensor_regs_pkg;

    // register addresses on the serial register interface
    localparam logic [7:0] ADDR_DATA_STATUS = 8'h00;
    localparam logic [7:0] ADDR_X_MSB = 8'h01;
    localparam logic [7:0] ADDR_Y_MSB = 8'h03;
    localparam logic [7:0] ADDR_Z_MSB = 8'h05;
    localparam logic [7:0] ADDR_SYSTEM_MODE = 8'h0B;
    localparam logic [7:0] ADDR_IRQ_SUMMARY = 8'h0C;
    localparam logic [7:0] ADDR_IDENTITY = 8'h0D;
    localparam logic [7:0] ADDR_DATA_CFG = 8'h0E;
    localparam logic [7:0] ADDR_HP_CUTOFF = 8'h0F;

    // interrupt summary bit positions
    localparam int BIT_SLEEP_WAKE = 7;
    localparam int BIT_TRANSIENT = 5;
    localparam int BIT_ORIENT = 4;
    localparam int BIT_TAP = 3;
    localparam int BIT_FFMT = 2;
    localparam int BIT_DRDY = 0;

    // configuration field positions
    localparam int BIT_HIGHPASS_OUTPUT_SELECT = 4;
    localparam int BIT_TAP_HPF_BYP = 5;
    localparam int BIT_TAP_LPF_EN = 4;

    // values after reset, and the reserved full-scale code
    localparam logic [1:0] FS_RESET = 2'h0;
    localparam logic [1:0] FS_RESERVED = 2'h3;
    localparam logic [7:0] CUTOFF_RESET = 8'h00;

    // identity value, arbitrary
    localparam logic [7:0] IDENTITY_VALUE = 8'h5C;

    // clk_sys cycles per inactivity limit step
    localparam logic [15:0] STEP_CYCLES = 16'h0010;

    // operating state, gray along standby -> wake -> sleep
    typedef enum logic [1:0] {
        ST_STANDBY = 2'h0,
        ST_WAKE = 2'h1,
        ST_SLEEP = 2'h3
    } op_state_t;

    // reported field codes
    localparam logic [1:0] MODE_STANDBY = 2'h0;
    localparam logic [1:0] MODE_WAKE = 2'h1;
    localparam logic [1:0] MODE_SLEEP = 2'h2;

endpackage

// ### design/mode_sequencer.sv
// automatic sleep and wake sequencer with inactivity timer
// assumes event inputs come from logic on clk_sys
`timescale 1ns/100ps
`default_nettype none
module mode_sequencer
    import sensor_regs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic device_active,
    input wire logic auto_sleep_en,
    input wire logic [7:0] inactivity_limit,
    input wire logic any_irq,
    input wire logic wake_event,
    output var op_state_t state,
    output logic transition
);
    op_state_t state_q, state_d;
    logic [15:0] step_q;
    logic [7:0] steps_q;
    wire step_end = (step_q == STEP_CYCLES - 16'h0001);
    wire timed_out = step_end && (steps_q >= inactivity_limit);
    wire counting = (state_q == ST_WAKE) && auto_sleep_en && !any_irq;

    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_STANDBY: if (device_active) state_d = ST_WAKE;
            ST_WAKE: begin
                if (!device_active) state_d = ST_STANDBY;
                // R06: idle too long
                else if (counting && timed_out) state_d = ST_SLEEP;
            end
            ST_SLEEP: begin
                if (!device_active) state_d = ST_STANDBY;
                // R07: wake event
                else if (wake_event || !auto_sleep_en) state_d = ST_WAKE;
            end
            default: state_d = ST_STANDBY;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (srst) state_q <= ST_STANDBY;
        else state_q <= state_d;
    end

    // inactivity timer, restarted by any interrupt
    always_ff @(posedge clk_sys) begin
        if (srst || !counting) begin
            step_q <= 16'h0000;
            steps_q <= 8'h00;
        end else if (step_end) begin
            step_q <= 16'h0000;
            steps_q <= steps_q + 8'h01;
        end else begin
            step_q <= step_q + 16'h0001;
        end
    end

    assign state = state_q;
    assign transition = device_active && (state_d != state_q)
        && (state_q != ST_STANDBY) && (state_d != ST_STANDBY);
endmodule // mode_sequencer
`default_nettype wire

// ### design/sensor_mode_irq_status_config.sv
// system mode, interrupt summary, identity and output configuration
// assumes the serial interface supplies address with one-cycle strobes
// Overview of operation
// R01: two-bit mode field 00 standby 01 wake 10 sleep, upper bits zero
// R02: host polls the mode field to track sleep and wake changes
// R03: summary flags set on rising source edge, cleared by source read
// R04: summary bits 7,5,4,3,2,0 hold the six flags; 6 and 1 zero
// R05: sleep/wake flag set on transition event, cleared by mode read
// R06: wake goes to sleep after inactivity limit, selecting low rate
// R07: sleep goes to wake on wake event, selecting high rate
// R08: transient flag follows enabled event active, cleared by its read
// R09: orientation flag follows enabled change flag, cleared by its read
// R10: tap flag follows enabled event active, cleared by its read
// R11: freefall flag follows enabled event active, cleared by its read
// R12: data ready flag follows enabled new-data or overwrite flags
// R13: data ready clears on axis data read, not status read
// R14: identity register read only, fixed value
// R15: high-pass select bit 4 routes filtered samples to axis outputs
// R16: full-scale select 00 2g 01 4g 10 8g, 11 reserved, reset 00
// R17: cut-off chosen from programmed selection and current sample rate
// R18: all-axis flags clear once every enabled axis high byte is read
// R19: summary enables come from external interrupt enable inputs
`timescale 1ns/100ps
`default_nettype none
module sensor_mode_irq_status_config
    import sensor_regs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd_stb,
    input wire logic reg_wr_stb,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic device_active,
    input wire logic auto_sleep_en,
    input wire logic [7:0] inactivity_limit,
    input wire logic [2:0] wake_rate_sel,
    input wire logic [2:0] sleep_rate_sel,
    input wire logic wake_event,
    input wire logic any_irq,
    input wire logic transient_event_active_flag,
    input wire logic orientation_change_flag,
    input wire logic tap_event_active_flag,
    input wire logic freefall_motion_event_active_flag,
    input wire logic en_transient,
    input wire logic en_orientation,
    input wire logic en_tap,
    input wire logic en_freefall_motion,
    input wire logic en_data_ready,
    input wire logic transient_source_register_rd,
    input wire logic orientation_status_register_rd,
    input wire logic tap_source_register_rd,
    input wire logic freefall_motion_source_register_rd,
    input wire logic sample_stb,
    input wire logic [35:0] raw_sample,
    input wire logic [35:0] hp_sample,
    input wire logic [2:0] axis_enable,
    output logic [35:0] axis_out,
    output logic all_axis_new_data_flag,
    output logic all_axis_overwrite_flag,
    output logic [1:0] operating_state_field,
    output logic [2:0] output_sample_rate,
    output logic [1:0] full_scale_select,
    output logic highpass_output_select,
    output logic [4:0] effective_cutoff_code,
    output logic tap_hpf_bypass,
    output logic tap_lpf_enable,
    output logic [7:0] interrupt_source_summary
);
    // field code for a state
    function automatic logic [1:0] mode_code(input op_state_t s);
        case (s)
            ST_WAKE: mode_code = MODE_WAKE;
            ST_SLEEP: mode_code = MODE_SLEEP;
            default: mode_code = MODE_STANDBY;
        endcase
    endfunction

    // sticky summary flag: set wins over clear
    function automatic logic flag_next(input logic cur, input logic set,
                                       input logic clr);
        flag_next = set | (cur & ~clr);
    endfunction

    op_state_t state;
    logic transition;
    logic sleep_wake_event_flag_q;
    logic transient_summary_flag_q, orientation_summary_flag_q;
    logic tap_summary_flag_q, freefall_motion_summary_flag_q;
    logic data_ready_summary_flag_q;
    logic [4:0] src_prev_q;
    logic [2:0] msb_read_q;
    logic new_data_q, overwrite_q;
    logic [35:0] axis_q;
    logic [1:0] fs_q;
    logic highpass_output_select_q;
    logic [7:0] cutoff_q;
    logic [7:0] rdata_q;
    logic [4:0] cutoff_code_q;

    mode_sequencer u_seq (
        .clk_sys(clk_sys),
        .srst(srst),
        .device_active(device_active),
        .auto_sleep_en(auto_sleep_en),
        .inactivity_limit(inactivity_limit),
        .any_irq(any_irq),
        .wake_event(wake_event),
        .state(state),
        .transition(transition)
    );

    // register decode
    wire rd_mode = reg_rd_stb && (reg_addr == ADDR_SYSTEM_MODE);
    wire wr_cfg = reg_wr_stb && (reg_addr == ADDR_DATA_CFG);
    wire wr_cut = reg_wr_stb && (reg_addr == ADDR_HP_CUTOFF);
    wire [2:0] msb_rd = {reg_rd_stb && (reg_addr == ADDR_Z_MSB),
                         reg_rd_stb && (reg_addr == ADDR_Y_MSB),
                         reg_rd_stb && (reg_addr == ADDR_X_MSB)};

    // qualified sources and their rising edges
    wire [4:0] src_now = {
        transient_event_active_flag & en_transient,
        orientation_change_flag & en_orientation,
        tap_event_active_flag & en_tap,
        freefall_motion_event_active_flag & en_freefall_motion,
        (new_data_q | overwrite_q) & en_data_ready};
    wire [4:0] src_rise = src_now & ~src_prev_q;

    // all enabled high bytes read, counting this cycle's read
    wire [2:0] read_seen = msb_read_q | msb_rd;
    wire all_read = ((read_seen & axis_enable) == axis_enable);
    wire data_clear = all_read && (msb_rd != 3'h0);

    // rate in use for the current state
    wire [2:0] rate_now = (state == ST_SLEEP) ? sleep_rate_sel
                                              : wake_rate_sel;
    wire [1:0] fs_wr = reg_wdata[1:0];

    // read mux
    // R04: summary bit placement
    wire [7:0] summary = {sleep_wake_event_flag_q, 1'b0,
        transient_summary_flag_q, orientation_summary_flag_q,
        tap_summary_flag_q, freefall_motion_summary_flag_q, 1'b0,
        data_ready_summary_flag_q};
    wire [7:0] cfg_rd = {3'h0, highpass_output_select_q, 2'h0, fs_q};
    wire [7:0] rd_mux =
        // R01: upper six bits zero
        (reg_addr == ADDR_SYSTEM_MODE) ? {6'h00, mode_code(state)} :
        // R15: axis high bytes
        (reg_addr == ADDR_X_MSB) ? axis_q[11:4] :
        (reg_addr == ADDR_Y_MSB) ? axis_q[23:16] :
        (reg_addr == ADDR_Z_MSB) ? axis_q[35:28] :
        (reg_addr == ADDR_IRQ_SUMMARY) ? summary :
        // R14: fixed identity
        (reg_addr == ADDR_IDENTITY) ? IDENTITY_VALUE :
        (reg_addr == ADDR_DATA_CFG) ? cfg_rd :
        (reg_addr == ADDR_HP_CUTOFF) ? cutoff_q : 8'h00;

    // read data capture
    always_ff @(posedge clk_sys) begin
        if (srst) rdata_q <= 8'h00;
        else if (reg_rd_stb) rdata_q <= rd_mux;
    end

    // source edge history
    always_ff @(posedge clk_sys) begin
        if (srst) src_prev_q <= 5'h00;
        else src_prev_q <= src_now;
    end

    // R05: transition event flag, mode read clears
    always_ff @(posedge clk_sys) begin
        if (srst) sleep_wake_event_flag_q <= 1'b0;
        else sleep_wake_event_flag_q <=
            flag_next(sleep_wake_event_flag_q, transition, rd_mode);
    end

    // R03 R19: edge set, own source read clears
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            transient_summary_flag_q <= 1'b0;
            orientation_summary_flag_q <= 1'b0;
            tap_summary_flag_q <= 1'b0;
            freefall_motion_summary_flag_q <= 1'b0;
        end else begin
            // R08: transient
            transient_summary_flag_q <= flag_next(transient_summary_flag_q,
                src_rise[4], transient_source_register_rd);
            // R09: orientation
            orientation_summary_flag_q <= flag_next(
                orientation_summary_flag_q, src_rise[3],
                orientation_status_register_rd);
            // R10: tap
            tap_summary_flag_q <= flag_next(tap_summary_flag_q,
                src_rise[2], tap_source_register_rd);
            // R11: freefall motion
            freefall_motion_summary_flag_q <= flag_next(
                freefall_motion_summary_flag_q, src_rise[1],
                freefall_motion_source_register_rd);
        end
    end

    // R12 R13: data ready flag, axis read clears
    always_ff @(posedge clk_sys) begin
        if (srst) data_ready_summary_flag_q <= 1'b0;
        else data_ready_summary_flag_q <= flag_next(
            data_ready_summary_flag_q, src_rise[0], data_clear);
    end

    // R18: high byte read tracking
    always_ff @(posedge clk_sys) begin
        if (srst || sample_stb || data_clear) msb_read_q <= 3'h0;
        else msb_read_q <= read_seen;
    end

    // R18: all-axis flags; new sample wins over clear for new data, clear wins for overwrite
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            new_data_q <= 1'b0;
            overwrite_q <= 1'b0;
        end else begin
            new_data_q <= flag_next(new_data_q, sample_stb, data_clear);
            overwrite_q <= flag_next(overwrite_q,
                sample_stb & new_data_q & ~data_clear, data_clear);
        end
    end

    // R15: filtered or raw sample into the axis outputs
    always_ff @(posedge clk_sys) begin
        if (srst) axis_q <= 36'h0;
        else if (sample_stb) axis_q <= highpass_output_select_q ? hp_sample : raw_sample;
    end

    // R16: output configuration, reserved range write ignored
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fs_q <= FS_RESET;
            highpass_output_select_q <= 1'b0;
        end else if (wr_cfg) begin
            highpass_output_select_q <= reg_wdata[BIT_HIGHPASS_OUTPUT_SELECT];
            if (fs_wr != FS_RESERVED) fs_q <= fs_wr;
        end
    end

    // cut-off configuration, unused bits held zero
    always_ff @(posedge clk_sys) begin
        if (srst) cutoff_q <= CUTOFF_RESET;
        else if (wr_cut) cutoff_q <= reg_wdata & 8'h33;
    end

    // R17: cut-off index from selection and current rate
    always_ff @(posedge clk_sys) begin
        if (srst) cutoff_code_q <= 5'h00;
        else cutoff_code_q <= {rate_now, cutoff_q[1:0]};
    end

    // R06 R07: rate follows the operating state
    assign output_sample_rate = rate_now;
    assign reg_rdata = rdata_q;
    assign axis_out = axis_q;
    assign all_axis_new_data_flag = new_data_q;
    assign all_axis_overwrite_flag = overwrite_q;
    assign operating_state_field = mode_code(state);
    assign full_scale_select = fs_q;
    assign highpass_output_select = highpass_output_select_q;
    assign effective_cutoff_code = cutoff_code_q;
    assign tap_hpf_bypass = cutoff_q[BIT_TAP_HPF_BYP];
    assign tap_lpf_enable = cutoff_q[BIT_TAP_LPF_EN];
    assign interrupt_source_summary = summary;

    // checks
    // R01: field never shows the unused code
    chk_mode_code: assert property ( // R01
        @(posedge clk_sys) disable iff (srst)
        operating_state_field != 2'h3)
        else $error("mode field shows code 11");
    // R05: flag set after a transition
    chk_sw_set: assert property ( // R05
        @(posedge clk_sys) disable iff (srst)
        transition |=> sleep_wake_event_flag_q)
        else $error("sleep wake flag not set");
    // R05: mode read clears without transition
    chk_sw_clr: assert property ( // R05
        @(posedge clk_sys) disable iff (srst)
        rd_mode && !transition |=> !sleep_wake_event_flag_q)
        else $error("sleep wake flag not cleared");
    // R03: flag holds until its read
    chk_tr_hold: assert property ( // R03
        @(posedge clk_sys) disable iff (srst)
        transient_summary_flag_q && !transient_source_register_rd
        |=> transient_summary_flag_q)
        else $error("transient flag lost");
    // R10: enabled rising edge sets tap flag
    chk_tap_set: assert property ( // R10
        @(posedge clk_sys) disable iff (srst)
        tap_event_active_flag && en_tap
        && !($past(tap_event_active_flag) && $past(en_tap))
        |=> tap_summary_flag_q)
        else $error("tap flag not set");
    // R09: disabled source never sets
    chk_or_mask: assert property ( // R09
        @(posedge clk_sys) disable iff (srst)
        !orientation_summary_flag_q && !en_orientation
        |=> !orientation_summary_flag_q)
        else $error("orientation flag set while disabled");
    // R13: status read alone leaves data ready set
    chk_dr_status: assert property ( // R13
        @(posedge clk_sys) disable iff (srst)
        data_ready_summary_flag_q && reg_rd_stb
        && reg_addr == ADDR_DATA_STATUS |=> data_ready_summary_flag_q)
        else $error("status read cleared data ready");
    // R12: first new sample raises data ready
    chk_dr_set: assert property ( // R12
        @(posedge clk_sys) disable iff (srst)
        sample_stb && en_data_ready && !new_data_q && !overwrite_q
        ##1 en_data_ready |=> data_ready_summary_flag_q)
        else $error("data ready flag not set");
    // R18: reading all three high bytes clears new data
    chk_new_clr: assert property ( // R18
        @(posedge clk_sys) disable iff (srst)
        axis_enable == 3'h7 && msb_rd == 3'h4 && msb_read_q == 3'h3
        && !sample_stb |=> !new_data_q)
        else $error("new data flag not cleared");
    // R16: reserved range never stored
    chk_fs_legal: assert property ( // R16
        @(posedge clk_sys) disable iff (srst)
        full_scale_select != FS_RESERVED)
        else $error("reserved full scale stored");
    // R15: filtered sample routed when select is set
    chk_hp_route: assert property ( // R15
        @(posedge clk_sys) disable iff (srst)
        sample_stb && highpass_output_select_q |=> axis_out == $past(hp_sample))
        else $error("filtered sample not routed");
    // R14: identity read returns fixed value
    chk_ident: assert property ( // R14
        @(posedge clk_sys) disable iff (srst)
        reg_rd_stb && reg_addr == ADDR_IDENTITY
        |=> reg_rdata == IDENTITY_VALUE)
        else $error("identity value wrong");
    // R06: sleep state selects low rate
    chk_rate: assert property ( // R06
        @(posedge clk_sys) disable iff (srst)
        operating_state_field == MODE_SLEEP
        |-> output_sample_rate == sleep_rate_sel)
        else $error("sleep rate not selected");

    cov_sleep: cover property (@(posedge clk_sys) disable iff (srst)
        operating_state_field == MODE_WAKE
        ##1 operating_state_field == MODE_SLEEP);
    cov_wake: cover property (@(posedge clk_sys) disable iff (srst)
        operating_state_field == MODE_SLEEP
        ##1 operating_state_field == MODE_WAKE);
    cov_overrun: cover property (@(posedge clk_sys) disable iff (srst)
        overwrite_q && data_ready_summary_flag_q);
endmodule // sensor_mode_irq_status_config
`default_nettype wire

// ### dv/host_model.sv
// host side of the register bus: one-cycle read and write strobes
// assumes the bench calls rd and wr; lines change on the falling edge
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic clk_sys,
    output logic [7:0] reg_addr,
    output logic reg_rd_stb,
    output logic reg_wr_stb,
    output logic [7:0] reg_wdata
);
    // bus idle at time zero
    initial begin
        reg_addr = 8'hFF;
        reg_rd_stb = 1'b0;
        reg_wr_stb = 1'b0;
        reg_wdata = 8'hFF;
    end
    // one strobe cycle, then lines released to the inverse
    task automatic xfer(input logic [7:0] a, input logic [7:0] d,
        input logic w);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_rd_stb = !w;
        reg_wr_stb = w;
        @(negedge clk_sys);
        reg_rd_stb = 1'b0;
        reg_wr_stb = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        xfer(a, 8'h00, 1'b0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, d, 1'b1);
    endtask
endmodule // host_model
`default_nettype wire

// ### dv/sensor_mode_irq_status_config_tb.sv
// self-checking bench for mode, summary, identity and config registers
// assumes host_model drives the register bus; reads scored from a queue
`timescale 1ns/100ps
`default_nettype none
module sensor_mode_irq_status_config_tb;
    import sensor_regs_pkg::*;
    logic clk_sys = 1'b0, srst = 1'b1, rd_seen = 1'b0;
    logic device_active = 1'b0, auto_sleep_en = 1'b0, wake_event = 1'b0;
    logic any_irq = 1'b0, en_drdy = 1'b0, sample_stb = 1'b0;
    logic [7:0] inactivity_limit = 8'h01, e_now, a_now;
    logic [2:0] wake_rate_sel = 3'h0, sleep_rate_sel = 3'h0;
    logic [2:0] axis_enable = 3'h7, k;
    logic [3:0] ev = 4'h0, en = 4'h0, clr = 4'h0;
    logic [35:0] raw_sample = '0, hp_sample = '0;
    logic [31:0] seed = 32'h5c36;
    wire logic [7:0] reg_addr, reg_wdata, reg_rdata, irq_sum;
    wire logic reg_rd_stb, reg_wr_stb, new_f, ovw_f, hpf, byp, lpf;
    wire logic [35:0] axis_out;
    wire logic [1:0] mode_f, fs;
    wire logic [2:0] rate;
    wire logic [4:0] cut;
    logic [7:0] exp_q[$], adr_q[$];
    bit chk_q[$];
    int mismatches = 0, samples_checked = 0, cycles = 0, i;
    // clock at 25 MHz
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    host_model u_host (.clk_sys(clk_sys), .reg_addr(reg_addr),
        .reg_rd_stb(reg_rd_stb), .reg_wr_stb(reg_wr_stb),
        .reg_wdata(reg_wdata));
    sensor_mode_irq_status_config u_dut (.clk_sys(clk_sys), .srst(srst),
        .reg_addr(reg_addr), .reg_rd_stb(reg_rd_stb),
        .reg_wr_stb(reg_wr_stb), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .device_active(device_active),
        .auto_sleep_en(auto_sleep_en), .inactivity_limit(inactivity_limit),
        .wake_rate_sel(wake_rate_sel), .sleep_rate_sel(sleep_rate_sel),
        .wake_event(wake_event), .any_irq(any_irq),
        .transient_event_active_flag(ev[0]),
        .orientation_change_flag(ev[1]), .tap_event_active_flag(ev[2]),
        .freefall_motion_event_active_flag(ev[3]), .en_transient(en[0]),
        .en_orientation(en[1]), .en_tap(en[2]),
        .en_freefall_motion(en[3]), .en_data_ready(en_drdy),
        .transient_source_register_rd(clr[0]),
        .orientation_status_register_rd(clr[1]),
        .tap_source_register_rd(clr[2]),
        .freefall_motion_source_register_rd(clr[3]),
        .sample_stb(sample_stb), .raw_sample(raw_sample),
        .hp_sample(hp_sample), .axis_enable(axis_enable),
        .axis_out(axis_out), .all_axis_new_data_flag(new_f),
        .all_axis_overwrite_flag(ovw_f), .operating_state_field(mode_f),
        .output_sample_rate(rate), .full_scale_select(fs),
        .highpass_output_select(hpf), .effective_cutoff_code(cut),
        .tap_hpf_bypass(byp), .tap_lpf_enable(lpf),
        .interrupt_source_summary(irq_sum));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp_rd(input logic [7:0] a, e, s);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value reg_rdata at %h expected %h seen %h",
                a, e, s);
        end
    endtask
    task automatic cmp_port(input string n, input logic [35:0] s, e);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // note the expected byte, then issue the read
    task automatic rdc(input logic [7:0] a, e, input bit c = 1'b1);
        exp_q.push_back(e);
        adr_q.push_back(a);
        chk_q.push_back(c);
        u_host.rd(a);
    endtask
    // new sample pair from the shift register
    task automatic smp();
        @(negedge clk_sys);
        seed = lfsr(seed);
        raw_sample = {seed[3:0], seed};
        seed = lfsr(seed);
        hp_sample = {seed, seed[31:28]};
        sample_stb = 1'b1;
        @(negedge clk_sys);
        sample_stb = 1'b0;
    endtask
    // read data appears one cycle after the strobe edge
    always @(posedge clk_sys) rd_seen <= reg_rd_stb;
    always @(negedge clk_sys) begin
        if (rd_seen && exp_q.size() > 0) begin
            e_now = exp_q.pop_front();
            a_now = adr_q.pop_front();
            if (chk_q.pop_front()) cmp_rd(a_now, e_now, reg_rdata);
        end
    end
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end
    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        srst = 1'b0;
        cmp_port("full_scale_select", 36'(fs), 36'(FS_RESET));
        cmp_port("operating_state_field", 36'(mode_f), 36'h0);
        rdc(ADDR_SYSTEM_MODE, 8'h00);
        rdc(ADDR_IRQ_SUMMARY, 8'h00);
        rdc(ADDR_DATA_CFG, 8'h00);
        rdc(8'h40, 8'h00);
        u_host.wr(ADDR_IDENTITY, 8'hA5);
        rdc(ADDR_IDENTITY, IDENTITY_VALUE);
        for (k = 3'h0; k < 3'h3; k++) begin
            u_host.wr(ADDR_DATA_CFG, {3'h0, k[0], 2'h0, k[1:0]});
            rdc(ADDR_DATA_CFG, {3'h0, k[0], 2'h0, k[1:0]});
            cmp_port("full_scale_select", 36'(fs), 36'(k[1:0]));
        end
        u_host.wr(ADDR_DATA_CFG, 8'h13);
        rdc(ADDR_DATA_CFG, 8'h12);
        cmp_port("highpass_output_select", 36'(hpf), 36'h1);
        u_host.wr(ADDR_HP_CUTOFF, 8'hFF);
        rdc(ADDR_HP_CUTOFF, 8'h33);
        cmp_port("tap_hpf_bypass", 36'({byp, lpf}), 36'h3);
        seed = lfsr(seed);
        wake_rate_sel = seed[2:0];
        sleep_rate_sel = ~seed[2:0];
        device_active = 1'b1;
        auto_sleep_en = 1'b1;
        repeat (20) @(negedge clk_sys);
        rdc(ADDR_SYSTEM_MODE, 8'h01);
        cmp_port("output_sample_rate", 36'(rate), 36'(wake_rate_sel));
        repeat (20) @(negedge clk_sys);
        rdc(ADDR_IRQ_SUMMARY, 8'h80);
        rdc(ADDR_SYSTEM_MODE, 8'h02);
        rdc(ADDR_IRQ_SUMMARY, 8'h00);
        cmp_port("output_sample_rate", 36'(rate), 36'(sleep_rate_sel));
        cmp_port("cutoff", 36'(cut), 36'({sleep_rate_sel, 2'h3}));
        wake_event = 1'b1;
        @(negedge clk_sys);
        wake_event = 1'b0;
        auto_sleep_en = 1'b0;
        repeat (2) @(negedge clk_sys);
        rdc(ADDR_IRQ_SUMMARY, 8'h80);
        rdc(ADDR_SYSTEM_MODE, 8'h01);
        cmp_port("output_sample_rate", 36'(rate), 36'(wake_rate_sel));
        for (i = 0; i < 4; i++) begin
            ev[i] = 1'b1;
            repeat (2) @(negedge clk_sys);
            ev[i] = 1'b0;
            rdc(ADDR_IRQ_SUMMARY, 8'h00);
            en[i] = 1'b1;
            @(negedge clk_sys);
            ev[i] = 1'b1;
            repeat (2) @(negedge clk_sys);
            cmp_port("interrupt_source_summary", 36'(irq_sum),
                36'(8'h20 >> i));
            rdc(ADDR_IRQ_SUMMARY, 8'h20 >> i);
            clr[i] = 1'b1;
            @(negedge clk_sys);
            clr[i] = 1'b0;
            rdc(ADDR_IRQ_SUMMARY, 8'h00);
            ev[i] = 1'b0;
            en[i] = 1'b0;
        end
        en_drdy = 1'b1;
        smp();
        cmp_port("axis_out", axis_out, hp_sample);
        repeat (2) @(negedge clk_sys);
        rdc(ADDR_IRQ_SUMMARY, 8'h01);
        rdc(ADDR_DATA_STATUS, 8'h00, 1'b0);
        rdc(ADDR_IRQ_SUMMARY, 8'h01);
        rdc(ADDR_X_MSB, hp_sample[11:4]);
        rdc(ADDR_Y_MSB, hp_sample[23:16]);
        cmp_port("all_axis_new_data_flag", 36'(new_f), 36'h1);
        rdc(ADDR_Z_MSB, hp_sample[35:28]);
        cmp_port("all_axis_new_data_flag", 36'(new_f), 36'h0);
        rdc(ADDR_IRQ_SUMMARY, 8'h00);
        u_host.wr(ADDR_DATA_CFG, 8'h00);
        smp();
        smp();
        cmp_port("axis_out", axis_out, raw_sample);
        cmp_port("all_axis_overwrite_flag", 36'(ovw_f), 36'h1);
        rdc(ADDR_X_MSB, raw_sample[11:4]);
        rdc(ADDR_Y_MSB, raw_sample[23:16]);
        rdc(ADDR_Z_MSB, raw_sample[35:28]);
        cmp_port("all_axis_overwrite_flag", 36'(ovw_f), 36'h0);
        repeat (4) @(negedge clk_sys);
        stop_test();
    end
endmodule // sensor_mode_irq_status_config_tb
`default_nettype wire
